// >>> core/tks_pkg.sv
// Constants, types and register map of the touch key scan counter
package tks_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned DONE_LAG_NS  = 3000;
    // Longest time, so rounded down
    localparam int unsigned DONE_LAG_CYC = DONE_LAG_NS * CLK_MHZ / 1000;

    // ----------------------------------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_CNT_LO  = 8'h1a;
    localparam logic [7:0] IDX_CNT_HI  = 8'h1b;
    localparam logic [7:0] IDX_TGT_LO  = 8'h1c;
    localparam logic [7:0] IDX_TGT_HI  = 8'h1d;
    localparam logic [7:0] IDX_CFG     = 8'h1e;
    localparam logic [7:0] IDX_CTL     = 8'h1f;
    localparam logic [7:0] ADDR_CNT_LO = IDX_CNT_LO << 2;
    localparam logic [7:0] ADDR_CNT_HI = IDX_CNT_HI << 2;
    localparam logic [7:0] ADDR_TGT_LO = IDX_TGT_LO << 2;
    localparam logic [7:0] ADDR_TGT_HI = IDX_TGT_HI << 2;
    localparam logic [7:0] ADDR_CFG    = IDX_CFG << 2;
    localparam logic [7:0] ADDR_CTL    = IDX_CTL << 2;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int unsigned CTL_SOC_BIT  = 5;
    localparam int unsigned CHAN_REF_BIT = 3;
    localparam int unsigned NUM_KEYS     = 8;
    localparam logic [7:0]  CFG_RST      = 8'h84;
    localparam logic [7:0]  CTL_RST      = 8'h1f;
    localparam logic [11:0] TGT_RST      = 12'h0ff;
    localparam logic [7:0]  REF_BASE_CYC = 8'h08;
    localparam logic [7:0]  REF_STEP_CYC = 8'h02;
    localparam logic [1:0]  FSL_MAX      = 2'h3;

    typedef enum logic [1:0] {TKS_IDLE, TKS_SETTLE, TKS_COUNT} tks_fsm_e;

    typedef struct packed {
        logic       powerDown;
        logic       autoAdjust;
        logic       countDouble;
        logic [1:0] freqSel;
        logic [2:0] refCap;
    } tks_cfg_s;

    typedef struct packed {
        logic       irqPending;
        logic       irqEnable;
        logic       startBit;
        logic       doneFlag;
        logic [3:0] channel;
    } tks_ctl_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wrData;
    } tks_bus_req_s;

    typedef struct packed {
        tks_fsm_e   fsm;
        tks_cfg_s   cfg;
        tks_ctl_s   ctl;
        logic [11:0] target;
        logic [11:0] result;
        logic [11:0] dataCnt;
        logic [11:0] refCnt;
        logic [7:0]  divCnt;
        logic [9:0]  settleCnt;
        logic        everOn;
        logic [7:0]  rdData;
    } tks_state_s;

endpackage : tks_pkg

// >>> core/tks_touch_key_scan.sv
// Touch key scan counter: registers, conversion sequencer, counters, pads
`timescale 1ns/1ps
module tks_touch_key_scan
    import tks_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire tks_bus_req_s busReq,
    output logic [7:0]        regRdData,
    input  wire logic [8:0]   touchOscTick,
    output logic [7:0]        keyPadOut,
    output logic [7:0]        keyPadOe,
    output logic [1:0]        oscFreqSel,
    output logic              touchOscAutoAdjust,
    output logic              senseEnable,
    output logic              irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    tks_state_s s_r;
    tks_state_s s_nxt;

    logic       refTick;
    logic       touchTick;
    logic       endConv;
    logic       startGo;
    logic       swStop;
    logic       busy;
    logic [7:0] refPeriod;
    tks_ctl_s   wrCtl;
    tks_cfg_s   wrCfg;

    assign wrCtl = tks_ctl_s'(busReq.wrData);
    assign wrCfg = tks_cfg_s'(busReq.wrData);
    assign busy  = (s_r.fsm != TKS_IDLE);

    // Slower cap or lower band both stretch the period
    assign refPeriod = 8'((REF_BASE_CYC + REF_STEP_CYC * 8'(s_r.cfg.refCap))
                          << (FSL_MAX - s_r.cfg.freqSel));

    // Code with top bit set routes the internal reference
    assign touchTick = s_r.ctl.channel[CHAN_REF_BIT] ? touchOscTick[8]
                     : touchOscTick[s_r.ctl.channel[2:0]];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_nxt   = s_r;
        refTick = 1'b0;
        endConv = 1'b0;
        startGo = 1'b0;
        swStop  = 1'b0;
        s_nxt.rdData = 8'h00;

        if (busReq.rd)
        begin
            case (busReq.addr)
                ADDR_CNT_LO: s_nxt.rdData = s_r.result[7:0];
                ADDR_CNT_HI: s_nxt.rdData = {4'h0, s_r.result[11:8]};
                ADDR_TGT_LO: s_nxt.rdData = s_r.target[7:0];
                ADDR_TGT_HI: s_nxt.rdData = {4'h0, s_r.target[11:8]};
                ADDR_CFG:    s_nxt.rdData = s_r.cfg;
                ADDR_CTL:    s_nxt.rdData = s_r.ctl;
                default:     s_nxt.rdData = 8'h00;
            endcase
        end

        if (busReq.wr)
        begin
            case (busReq.addr)
                ADDR_TGT_LO: s_nxt.target[7:0]  = busReq.wrData;
                ADDR_TGT_HI: s_nxt.target[11:8] = busReq.wrData[3:0];
                ADDR_CFG:    s_nxt.cfg          = wrCfg;
                ADDR_CTL:
                begin
                    s_nxt.ctl.irqEnable = wrCtl.irqEnable;
                    s_nxt.ctl.channel   = wrCtl.channel;
                    if (!wrCtl.irqPending)
                        s_nxt.ctl.irqPending = 1'b0;
                    if (wrCtl.startBit && !s_r.ctl.startBit
                        && !s_r.cfg.powerDown)
                        startGo = 1'b1;
                    if (!wrCtl.startBit && s_r.ctl.startBit)
                        swStop = 1'b1;
                end
                default: ;
            endcase
        end

        // First enable of the block raises pending once
        if (busReq.wr && busReq.addr == ADDR_CFG && !wrCfg.powerDown
            && !s_r.everOn)
        begin
            s_nxt.everOn         = 1'b1;
            s_nxt.ctl.irqPending = 1'b1;
        end

        // Reference oscillator divider
        if (busy && s_r.divCnt >= refPeriod - 8'h01)
        begin
            refTick = 1'b1;
        end

        case (s_r.fsm)
            TKS_IDLE:
            begin
                s_nxt.divCnt = 8'h00;
            end
            TKS_SETTLE:
            begin
                // Oscillators start up before counting
                if (s_r.settleCnt == 10'h000)
                    s_nxt.fsm = TKS_COUNT;
                else
                    s_nxt.settleCnt = s_r.settleCnt - 10'h001;
            end
            TKS_COUNT:
            begin
                s_nxt.divCnt = refTick ? 8'h00 : s_r.divCnt + 8'h01;
                if (touchTick)
                    s_nxt.dataCnt = s_r.dataCnt + 12'h001;
                if (refTick)
                    s_nxt.refCnt = s_r.refCnt + 12'h001;
                if (s_r.refCnt == s_r.target)
                    endConv = 1'b1;
            end
            default:
            begin
                s_nxt.fsm = TKS_IDLE;
            end
        endcase

        if (startGo)
        begin
            s_nxt.fsm            = TKS_SETTLE;
            s_nxt.settleCnt      = 10'(DONE_LAG_CYC - 1);
            s_nxt.refCnt         = 12'h000;
            s_nxt.dataCnt        = 12'h000;
            s_nxt.divCnt         = 8'h00;
            s_nxt.ctl.startBit   = 1'b1;
            s_nxt.ctl.doneFlag   = 1'b0;
            s_nxt.ctl.irqPending = 1'b0;
        end
        else if (swStop || s_r.cfg.powerDown)
        begin
            s_nxt.fsm          = TKS_IDLE;
            s_nxt.ctl.startBit = 1'b0;
        end
        else if (endConv)
        begin
            // Auto-clear is exact here; slow-clock loss cannot occur
            s_nxt.fsm            = TKS_IDLE;
            s_nxt.ctl.startBit   = 1'b0;
            s_nxt.ctl.doneFlag   = 1'b1;
            s_nxt.ctl.irqPending = 1'b1;
            // Doubling drops the top bit of large counts
            s_nxt.result = s_r.cfg.countDouble
                ? {s_r.dataCnt[10:0], 1'b0} : s_r.dataCnt;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_r           <= '0;
            s_r.fsm       <= TKS_IDLE;
            s_r.cfg       <= tks_cfg_s'(CFG_RST);
            s_r.ctl       <= tks_ctl_s'(CTL_RST);
            s_r.target    <= TGT_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign regRdData          = s_r.rdData;
    assign irq                = s_r.ctl.irqPending & s_r.ctl.irqEnable;
    assign oscFreqSel         = s_r.cfg.freqSel;
    assign touchOscAutoAdjust = s_r.cfg.autoAdjust;
    assign senseEnable        = !s_r.cfg.powerDown;

    genvar k;
    generate
        for (k = 0; k < NUM_KEYS; k++)
        begin : g_pad
            // Only the scanned key floats; others drive low
            assign keyPadOut[k] = 1'b0;
            assign keyPadOe[k]  = !(busy && !s_r.ctl.channel[CHAN_REF_BIT]
                                   && s_r.ctl.channel[2:0] == 3'(k));
        end
    endgenerate

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sStart;
        startGo;
    endsequence

    sequence sSettle;
        (s_r.fsm == TKS_SETTLE)[*8];
    endsequence

    a_done_drop: assert property (sStart |=> !s_r.ctl.doneFlag)
        else $error("done not low after start");
    a_settle_run: assert property (sStart |=> sSettle)
        else $error("settle phase cut short");
    a_end_clear: assert property (endConv && !s_r.cfg.powerDown && !swStop
        |=> !s_r.ctl.startBit && s_r.ctl.doneFlag && !busy)
        else $error("end of conversion not completed");
    a_end_pend: assert property (endConv && !swStop && !s_r.cfg.powerDown
        |=> s_r.ctl.irqPending)
        else $error("pending not set at end");
    a_end_target: assert property (endConv
        |-> s_r.fsm == TKS_COUNT && s_r.refCnt == s_r.target)
        else $error("end away from target");
    a_result_val: assert property (endConv && !swStop && !s_r.cfg.powerDown
        |=> s_r.result == ($past(s_r.cfg.countDouble)
            ? 12'($past(s_r.dataCnt) << 1) : $past(s_r.dataCnt)))
        else $error("result not latched");
    a_sw_stop: assert property (swStop && !startGo
        |=> !busy && !s_r.ctl.startBit)
        else $error("cancel ignored");
    a_pd_idle: assert property (s_r.cfg.powerDown && !startGo |=> !busy)
        else $error("runs while powered down");
    a_irq_gate: assert property (irq |-> s_r.ctl.irqEnable
        && s_r.ctl.irqPending)
        else $error("interrupt not gated");
    a_idle_pad: assert property (!busy |-> keyPadOe == 8'hff
        && keyPadOut == 8'h00)
        else $error("idle pad not driven low");
    a_ref_space: assert property (refTick |=> !refTick)
        else $error("reference ticks too close");

    // ----------------------------------------------------------------
    // Pending flag, start bit, sequencing, counters, read port and pads
    // ----------------------------------------------------------------
    sequence sEnd;
        endConv && !swStop && !s_r.cfg.powerDown;
    endsequence

    sequence sSettleDone;
        s_r.fsm == TKS_SETTLE && s_r.settleCnt == 10'h000
            && !swStop && !s_r.cfg.powerDown && !startGo;
    endsequence

    a_pend_keep: assert property (s_r.ctl.irqPending && !startGo
        && !(busReq.wr && busReq.addr == ADDR_CTL && !wrCtl.irqPending)
        |=> s_r.ctl.irqPending)
        else $error("pending lost without clear");
    a_pend_wclr: assert property (busReq.wr && busReq.addr == ADDR_CTL
        && !wrCtl.irqPending && !(endConv && !swStop && !s_r.cfg.powerDown)
        |=> !s_r.ctl.irqPending)
        else $error("pending not cleared by write");
    a_start_go: assert property (startGo
        |=> s_r.ctl.startBit && busy && !s_r.ctl.irqPending)
        else $error("start not taken");
    a_start_pd: assert property (busReq.wr && busReq.addr == ADDR_CTL
        && wrCtl.startBit && s_r.cfg.powerDown
        |=> !s_r.ctl.startBit && !busy)
        else $error("start taken while powered down");
    a_done_busy: assert property (busy |-> !s_r.ctl.doneFlag)
        else $error("done high while busy");
    a_settle_end: assert property (sSettleDone |=> s_r.fsm == TKS_COUNT)
        else $error("settle did not end");
    a_end_seq: assert property (sEnd |=> !busy ##1 !busy)
        else $error("busy after end");
    a_count_hold: assert property (s_r.fsm != TKS_COUNT && !startGo
        |=> $stable(s_r.dataCnt))
        else $error("data counter runs outside count");
    a_result_hold: assert property (!endConv |=> $stable(s_r.result))
        else $error("result changed outside end");
    a_rd_low: assert property (busReq.rd && busReq.addr == ADDR_CNT_LO
        |=> regRdData == $past(s_r.result[7:0]))
        else $error("low count byte wrong");
    a_rd_high: assert property (busReq.rd && busReq.addr == ADDR_CNT_HI
        |=> regRdData == {4'h0, $past(s_r.result[11:8])})
        else $error("high count nibble wrong");
    a_rd_idle: assert property (!busReq.rd |=> regRdData == 8'h00)
        else $error("read data outside read slot");
    a_pad_scan: assert property (busy && !s_r.ctl.channel[CHAN_REF_BIT]
        |-> keyPadOe == ~(8'h01 << s_r.ctl.channel[2:0]))
        else $error("scanned pad not released");
    a_pad_ref: assert property (busy && s_r.ctl.channel[CHAN_REF_BIT]
        |-> keyPadOe == 8'hff)
        else $error("pad released on reference scan");

endmodule : tks_touch_key_scan

// >>> sim/tks_key_pad_model.sv
// Behavioural touch electrodes: oscillators seen as tick pulses
`timescale 1ns/1ps
module tks_key_pad_model
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] keyPadOut,
    input  wire logic [7:0] keyPadOe,
    output logic [8:0]      touchOscTick
);
    // ------------------------------------------------------------
    // Oscillation
    // ------------------------------------------------------------
    // A pad held low by the block cannot oscillate, so only released pads tick
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            touchOscTick <= 9'h000;
        else
            touchOscTick <= {1'b1, ~keyPadOe & ~keyPadOut};
    end
endmodule : tks_key_pad_model

// >>> sim/tb_top.sv
// Self-checking bench of the touch key scan counter
`timescale 1ns/1ps
module tb_top
    import tks_pkg::*;
;
    typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} tks_row_s;
    logic         clk;
    logic         rst;
    tks_bus_req_s busReq;
    logic [7:0]   regRdData;
    logic [8:0]   touchOscTick;
    logic [7:0]   keyPadOut;
    logic [7:0]   keyPadOe;
    logic [1:0]   oscFreqSel;
    logic         touchOscAutoAdjust;
    logic         senseEnable;
    logic         irq;
    int           n_mismatch;
    int           check_count;
    logic [7:0]   rd;
    logic [7:0]   rdHi;
    int           span;
    tks_row_s     rows [9] = '{
        '{1'b0, ADDR_CTL, 8'h00, 8'h1f},
        '{1'b0, ADDR_CFG, 8'h00, 8'h84},
        '{1'b0, ADDR_TGT_LO, 8'h00, 8'hff},
        '{1'b0, ADDR_TGT_HI, 8'h00, 8'h00},
        '{1'b1, ADDR_CFG, 8'h18, 8'h18},
        '{1'b0, ADDR_CTL, 8'h00, 8'h9f},
        '{1'b1, ADDR_CTL, 8'h01, 8'h11},
        '{1'b1, ADDR_TGT_LO, 8'h04, 8'h04},
        '{1'b1, 8'h00, 8'haa, 8'h00}};

    tks_touch_key_scan tks_touch_key_scan_inst (.clk(clk), .rst(rst), .busReq(busReq),
        .regRdData(regRdData), .touchOscTick(touchOscTick), .keyPadOut(keyPadOut),
        .keyPadOe(keyPadOe), .oscFreqSel(oscFreqSel), .touchOscAutoAdjust(touchOscAutoAdjust),
        .senseEnable(senseEnable), .irq(irq));
    tks_key_pad_model tks_key_pad_model_inst (.clk(clk), .rst(rst), .keyPadOut(keyPadOut),
        .keyPadOe(keyPadOe), .touchOscTick(touchOscTick));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wrData: d};
        @(posedge clk);
        busReq <= '0;
        @(posedge clk);
    endtask : bus_write

    // Data stand only in the cycle after the strobe edge
    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wrData: 8'h00};
        @(posedge clk);
        busReq <= '0;
        @(posedge clk);
        d = regRdData;
    endtask : bus_read

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bus_read(a, d);
        chk($sformatf("reg %h", a), {4'h0, exp}, {4'h0, d});
    endtask : chk_reg

    task automatic complete_run();
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // Starts on channel ch and waits for the start bit to fall
    task automatic convert(input logic [7:0] cfg, input logic [3:0] ch, input int lo,
        input int hi);
        int i;
        bus_write(ADDR_CFG, cfg);
        bus_write(ADDR_CTL, {4'h4, ch});
        bus_write(ADDR_CTL, {4'h6, ch});
        chk_reg(ADDR_CTL, {4'h6, ch});
        chk("pad enable", {4'h0, ch[3] ? 8'hff : ~(8'h01 << ch[2:0])}, {4'h0, keyPadOe});
        chk("pad value", 12'h000, {4'h0, keyPadOut});
        rd = 8'h20;
        for (i = 0; i < 3000 && rd[CTL_SOC_BIT]; i++)
            bus_read(ADDR_CTL, rd);
        if (rd[CTL_SOC_BIT])
        begin
            n_mismatch++;
            complete_run();
        end
        chk_reg(ADDR_CTL, {4'hd, ch});
        chk("irq", 12'h001, {11'h0, irq});
        chk("pad idle", 12'h0ff, {4'h0, keyPadOe});
        bus_read(ADDR_CNT_LO, rd);
        bus_read(ADDR_CNT_HI, rdHi);
        check_count++;
        if (^{rdHi, rd} === 1'bx || {rdHi[3:0], rd} < lo || {rdHi[3:0], rd} > hi)
        begin
            n_mismatch++;
            $display("wrong value count expected %0d..%0d seen %h", lo, hi, {rdHi, rd});
        end
    endtask : convert

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        int f;
        int r;
        rst = 1'b1;
        busReq = '0;
        n_mismatch = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        chk("sense enable", 12'h000, {11'h0, senseEnable});
        @(posedge clk);
        foreach (rows[i])
        begin
            if (rows[i].wr)
                bus_write(rows[i].addr, rows[i].data);
            chk_reg(rows[i].addr, rows[i].exp);
        end
        for (int i = 0; i < 4; i++)
        begin
            f = 3 - i;
            r = (i * 3) % 8;
            span = 4 * ((8 + 2 * r) << (3 - f));
            convert({3'b000, f[1:0], r[2:0]}, 4'h1, span, span + 2);
        end
        convert(8'h38, 4'h1, 64, 68);
        convert(8'h18, 4'h8, 32, 34);
        bus_write(ADDR_CTL, 8'h81);
        chk_reg(ADDR_CTL, 8'h91);
        chk("irq masked", 12'h000, {11'h0, irq});
        bus_write(ADDR_CTL, 8'h41);
        chk_reg(ADDR_CTL, 8'h51);
        bus_write(ADDR_CTL, 8'h21);
        repeat (20) @(posedge clk);
        bus_write(ADDR_CTL, 8'h01);
        repeat (1200) @(posedge clk);
        chk_reg(ADDR_CTL, 8'h01);
        bus_write(ADDR_CFG, 8'h58);
        @(posedge clk);
        chk("freq sel", 12'h003, {10'h0, oscFreqSel});
        chk("auto adjust", 12'h001, {11'h0, touchOscAutoAdjust});
        chk("sense on", 12'h001, {11'h0, senseEnable});
        bus_write(ADDR_CFG, 8'h98);
        bus_write(ADDR_CTL, 8'h21);
        chk_reg(ADDR_CTL, 8'h01);
        chk("sense off", 12'h000, {11'h0, senseEnable});
        bus_write(ADDR_CFG, 8'h18);
        bus_write(ADDR_CTL, 8'h21);
        repeat (30) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("pad reset", 12'h0ff, {4'h0, keyPadOe});
        chk_reg(ADDR_CTL, 8'h1f);
        complete_run();
    end
endmodule : tb_top
